// >>> dccc_pkg.sv
// Purpose: constants and types for the duty-cycle calibration config block
// Assumes: 32-bit classic Wishbone register port, 100 MHz system clock
// Notes:   config word stores only its writable bits; the rest read as zero
package dccc_pkg;

	// register byte offsets
	localparam logic [7:0]  DCCC_CFG_OFS      = 8'h00; // duty_calibration_configuration
	localparam logic [7:0]  DCCC_ACC_OFS      = 8'h04; // acceleration / timing settings
	localparam logic [7:0]  DCCC_STS_OFS      = 8'h08; // sequencer status, read only
	localparam int          DCCC_ADR_W        = 8;     // decoded address bits

	// configuration word layout
	localparam logic [31:0] DCCC_CFG_RESET    = 32'h800a_9800;
	localparam logic [31:0] DCCC_CFG_RW_MASK  = 32'hfbff_ff30;
	localparam int          DCCC_GAIN_LSB     = 27;
	localparam int          DCCC_SPARE_BIT    = 25;
	localparam int          DCCC_SLOW_EN_BIT  = 24;
	localparam int          DCCC_FL_SEL_LSB   = 22;
	localparam int          DCCC_FL_EN_BIT    = 21;
	localparam int          DCCC_DECI_LSB     = 16;
	localparam int          DCCC_ROBUST_BIT   = 15;
	localparam int          DCCC_WRAP_LSB     = 13;
	localparam int          DCCC_LPF_LSB      = 8;
	localparam int          DCCC_HOLD_BIT     = 5;
	localparam int          DCCC_INT_BIT      = 4;
	localparam int          DCCC_RSVD_BIT     = 26;

	// acceleration word layout
	localparam logic [31:0] DCCC_ACC_RW_MASK  = 32'h000f_ffff;
	localparam int          DCCC_ACC_DUR_LSB  = 0;
	localparam int          DCCC_ACC_DLY_LSB  = 8;
	localparam int          DCCC_ACC_RATE_LSB = 16;
	localparam int          DCCC_ACC_RST_BIT  = 31;
	localparam logic [7:0]  DCCC_ACC_DUR_RST  = 8'h20;
	localparam logic [7:0]  DCCC_ACC_DLY_RST  = 8'h10;
	localparam logic [3:0]  DCCC_ACC_RATE_RST = 4'h0;

	// status word bit positions
	localparam int          DCCC_STS_ACCEL    = 0;
	localparam int          DCCC_STS_FAST     = 1;
	localparam int          DCCC_STS_WAIT     = 2;
	localparam int          DCCC_STS_SLOW     = 3;
	localparam int          DCCC_STS_CLKEN    = 4;
	localparam int          DCCC_STS_HOLD     = 5;
	localparam int          DCCC_STS_DACZ     = 6;
	localparam int          DCCC_STS_WRAP     = 7;

	// fast-lock coefficient for select code 0; codes step by one
	localparam logic [4:0]  DCCC_FL_COEF_BASE = 5'h0b;

	// phase wrap thresholds, in ring-oscillator steps
	localparam logic signed [7:0] DCCC_WRAP_SPAN = 8'sh22; // 34
	localparam logic [7:0]  DCCC_WRAP_THR_HI  = 8'h11;     // 17
	localparam logic [7:0]  DCCC_WRAP_THR_LO  = 8'h0c;     // 12

	// update base tick: one microsecond
	localparam int          DCCC_CLK_MHZ      = 100;
	localparam int          DCCC_BASE_US      = 1;
	localparam int          DCCC_BASE_CYC     = DCCC_BASE_US * DCCC_CLK_MHZ;

	// calibration sequencer states
	typedef enum logic [1:0] {
		DCCC_S_ACCEL,
		DCCC_S_RUN,
		DCCC_S_WAIT,
		DCCC_S_SLOW
	} dccc_state_t;

	// phase wrap select codes
	localparam logic [1:0]  DCCC_WRAP_NEAR    = 2'h0;
	localparam logic [1:0]  DCCC_WRAP_GT17    = 2'h1;
	localparam logic [1:0]  DCCC_WRAP_GT12    = 2'h2;

endpackage : dccc_pkg

// >>> dccc_phase_wrap.sv
// Purpose: phase wrap decision on a ring-oscillator cycle delta
// Assumes: delta is signed and its magnitude stays below 64
// Notes:   result registered on each update enable
`timescale 1ns/1ps
module dccc_phase_wrap
	import dccc_pkg::*;
(
	input  wire logic              sys_clk_in,   // system clock
	input  wire logic              reset_n_in,   // sync reset, active low
	input  wire logic              upd_in,       // update enable pulse
	input  wire logic [1:0]        sel_in,       // wrap algorithm select
	input  wire logic signed [7:0] delta_in,     // raw cycle delta
	output logic                   wrap_out,     // wrap assumed
	output logic signed [7:0]      delta_out     // wrap-corrected delta
);
	import dccc_pkg::*;

	typedef struct packed {
		logic              wrap;   // last decision
		logic signed [7:0] delta;  // last corrected delta
	} dccc_pw_t;

	dccc_pw_t          pw_q;       // registered state
	dccc_pw_t          pw_d;       // next state
	logic signed [7:0] plus_v;     // delta + span
	logic signed [7:0] minus_v;    // delta - span
	logic        [7:0] mag_v;      // |delta|
	logic        [7:0] mag_p;      // |delta + span|
	logic        [7:0] mag_m;      // |delta - span|

	// magnitudes of the three candidates
	always_comb
	begin
		plus_v  = delta_in + DCCC_WRAP_SPAN;
		minus_v = delta_in - DCCC_WRAP_SPAN;
		mag_v   = delta_in[7] ? 8'(-delta_in) : 8'(delta_in);
		mag_p   = plus_v[7] ? 8'(-plus_v) : 8'(plus_v);
		mag_m   = minus_v[7] ? 8'(-minus_v) : 8'(minus_v);
	end

	// pick the wrap test from the select code
	always_comb
	begin
		pw_d = pw_q;
		if (upd_in)
		begin
			pw_d.wrap  = 1'b0;
			pw_d.delta = delta_in;
			case (sel_in)
				DCCC_WRAP_GT17, DCCC_WRAP_GT12:
				begin
					// threshold codes shift the delta by one span against its sign
					if (mag_v > ((sel_in == DCCC_WRAP_GT17) ? DCCC_WRAP_THR_HI : DCCC_WRAP_THR_LO))
					begin
						pw_d.wrap  = 1'b1;
						pw_d.delta = delta_in[7] ? plus_v : minus_v;
					end
				end
				default:
				begin
					// nearest code; the unused code 3 behaves the same
					if (mag_p < mag_v)
					begin
						pw_d.wrap  = 1'b1;
						pw_d.delta = plus_v;
					end
					else if (mag_m < mag_v)
					begin
						pw_d.wrap  = 1'b1;
						pw_d.delta = minus_v;
					end
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge sys_clk_in)
	begin
		if (!reset_n_in)
			pw_q <= '0;
		else
			pw_q <= pw_d;
	end

	assign wrap_out  = pw_q.wrap;
	assign delta_out = pw_q.delta;

	// the 17-step threshold code never flags a delta whose magnitude is 17 or less
	wrap_thresh_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(upd_in && sel_in == DCCC_WRAP_GT17 && mag_v <= DCCC_WRAP_THR_HI) |=> !wrap_out)
		else $error("wrap flagged below threshold");

endmodule : dccc_phase_wrap

// >>> dccc_config.sv
// Purpose: duty-cycle calibration configuration register and mode sequencer
// Assumes: classic Wishbone slave, 32-bit data, pins synchronous to clock
// Notes:   acceleration runs after reset and on software restart
`timescale 1ns/1ps
module dccc_config
	import dccc_pkg::*;
(
	input  wire logic              sys_clk_in,      // 100 MHz system clock
	input  wire logic              reset_n_in,      // sync reset, active low
	input  wire logic              wb_cyc_i,        // bus cycle
	input  wire logic              wb_stb_i,        // strobe
	input  wire logic              wb_we_i,         // write enable
	input  wire logic [7:0]        wb_adr_i,        // byte address
	input  wire logic [3:0]        wb_sel_i,        // byte lanes
	input  wire logic [31:0]       wb_dat_i,        // write data
	output logic [31:0]            wb_dat_o,        // read data
	output logic                   wb_ack_o,        // acknowledge
	input  wire logic signed [7:0] ro_delta_in,     // ring-oscillator delta
	output logic [4:0]             gain_shift_out,  // slow filter gain shift
	output logic                   slow_mode_out,   // slow filter mode active
	output logic                   update_tick_out, // shared update enable
	output logic                   fast_lock_out,   // fast lock active
	output logic [4:0]             lpf_coef_out,    // lowpass coefficient in use
	output logic [4:0]             deci_coef_out,   // decimator coefficient
	output logic                   robust_out,      // robust state decode on
	output logic [1:0]             wrap_sel_out,    // phase wrap select
	output logic                   wrap_out,        // phase wrap seen
	output logic signed [7:0]      delta_out,       // corrected delta
	output logic                   dac_zero_out,    // force DAC output zero
	output logic                   holdover_out,    // calibration held
	output logic                   clocks_en_out    // output clocks may run
);
	import dccc_pkg::*;

	typedef struct packed {
		logic [31:0] cfg;     // configuration word
		logic [19:0] acc;     // acceleration settings
		dccc_state_t st;      // sequencer state
		logic [7:0]  pre;     // microsecond prescaler
		logic [3:0]  rcnt;    // update-rate counter
		logic [7:0]  tcnt;    // phase tick counter
		logic        tick;    // update pulse
		logic        clken;   // startup done
		logic        ack;     // bus acknowledge
		logic [31:0] rdat;    // read data
	} dccc_regs_t;

	localparam dccc_regs_t DCCC_REGS_RST = '{
		cfg:   DCCC_CFG_RESET,
		acc:   {DCCC_ACC_RATE_RST, DCCC_ACC_DLY_RST, DCCC_ACC_DUR_RST},
		st:    DCCC_S_ACCEL,
		pre:   '0,
		rcnt:  '0,
		tcnt:  '0,
		tick:  1'b0,
		clken: 1'b0,
		ack:   1'b0,
		rdat:  '0
	};

	dccc_regs_t  r_q;        // registered state
	dccc_regs_t  r_d;        // next state
	logic [31:0] wmask;      // byte-lane write mask
	logic        req;        // bus request pending
	logic        wr_take;    // write takes effect at this edge
	logic        hit_cfg;    // config register decoded
	logic        hit_acc;    // acceleration register decoded
	logic        hit_sts;    // status register decoded
	logic        restart;    // software restart of acceleration
	logic        slow_ok;    // slow mode allowed
	logic        fl_on;      // fast lock active
	logic [31:0] sts;        // status word
	logic [7:0]  acc_dur;    // acceleration duration, in update ticks
	logic [7:0]  acc_dly;    // slow start delay, in update ticks
	logic [3:0]  acc_rate;   // update rate, microseconds minus one
	logic        pw_wrap;    // wrap flag from decision unit
	logic signed [7:0] pw_delta; // corrected delta from decision unit

	// byte lanes expand into a bit mask
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lane
			assign wmask[8*gi +: 8] = {8{wb_sel_i[gi]}};
		end
	endgenerate

	// address decode and field views
	always_comb
	begin
		req      = wb_cyc_i && wb_stb_i;
		hit_cfg  = (wb_adr_i == DCCC_CFG_OFS);
		hit_acc  = (wb_adr_i == DCCC_ACC_OFS);
		hit_sts  = (wb_adr_i == DCCC_STS_OFS);
		wr_take  = req && wb_we_i && r_q.ack;
		restart  = wr_take && hit_acc && wb_sel_i[3] && wb_dat_i[DCCC_ACC_RST_BIT];
		acc_dur  = r_q.acc[DCCC_ACC_DUR_LSB +: 8];
		acc_dly  = r_q.acc[DCCC_ACC_DLY_LSB +: 8];
		acc_rate = r_q.acc[DCCC_ACC_RATE_LSB +: 4];
		// slow mode held off here too in case software forgets
		slow_ok  = r_q.cfg[DCCC_SLOW_EN_BIT] && !r_q.cfg[DCCC_INT_BIT]
			&& !r_q.cfg[DCCC_HOLD_BIT];
		// acceleration forces fast lock whatever the enable bit says
		fl_on    = (r_q.st == DCCC_S_ACCEL) || r_q.cfg[DCCC_FL_EN_BIT];
	end

	// status word from sequencer state, config hold bit, dac zero and wrap flag
	always_comb
	begin
		sts                 = '0;
		sts[DCCC_STS_ACCEL] = (r_q.st == DCCC_S_ACCEL);
		sts[DCCC_STS_FAST]  = fl_on;
		sts[DCCC_STS_WAIT]  = (r_q.st == DCCC_S_WAIT);
		sts[DCCC_STS_SLOW]  = (r_q.st == DCCC_S_SLOW);
		sts[DCCC_STS_CLKEN] = r_q.clken;
		sts[DCCC_STS_HOLD]  = r_q.cfg[DCCC_HOLD_BIT];
		sts[DCCC_STS_DACZ]  = dac_zero_out;
		sts[DCCC_STS_WRAP]  = pw_wrap;
	end

	// next-state logic: bus slave, rate divider, sequencer
	always_comb
	begin
		r_d      = r_q;
		r_d.tick = 1'b0;

		// ack answers one cycle after the request and drops the cycle after
		r_d.ack = req && !r_q.ack;
		if (req && !r_q.ack)
		begin
			if (hit_cfg)
				r_d.rdat = r_q.cfg;
			else if (hit_acc)
				r_d.rdat = {12'h000, r_q.acc};
			else if (hit_sts)
				r_d.rdat = sts;
			else
				r_d.rdat = '0; // unmapped reads zero
		end

		// writes land on the edge where the master sees ack
		if (wr_take && hit_cfg)
		begin
			// writable fields keep the value written
			// reserved bit masked out, always zero
			r_d.cfg = ((r_q.cfg & ~wmask) | (wb_dat_i & wmask)) & DCCC_CFG_RW_MASK;
		end
		if (wr_take && hit_acc)
		begin
			r_d.acc = 20'(((({12'h000, r_q.acc}) & ~wmask) | (wb_dat_i & wmask))
				& DCCC_ACC_RW_MASK);
		end

		// one update rate for every divider, in whole microseconds
		if (r_q.pre == 8'(DCCC_BASE_CYC - 1))
		begin
			r_d.pre = '0;
			if (r_q.rcnt >= acc_rate)
			begin
				r_d.rcnt = '0;
				r_d.tick = 1'b1;
			end
			else
				r_d.rcnt = r_q.rcnt + 4'h1;
		end
		else
			r_d.pre = r_q.pre + 8'h01;

		// accel and start-delay counts advance on update ticks only; slow_ok changes take effect at once
		case (r_q.st)
			DCCC_S_ACCEL:
			begin
				// from reset, clocks stay off for acc_dur + 1 update ticks
				if (r_q.tick)
				begin
					if (r_q.tcnt >= acc_dur)
					begin
						r_d.st    = DCCC_S_RUN;
						r_d.tcnt  = '0;
						r_d.clken = 1'b1;
					end
					else
						r_d.tcnt = r_q.tcnt + 8'h01;
				end
			end
			DCCC_S_RUN:
			begin
				r_d.tcnt = '0;
				if (slow_ok)
					r_d.st = DCCC_S_WAIT;
			end
			DCCC_S_WAIT:
			begin
				// slow start delay counted after acceleration ends
				if (!slow_ok)
					r_d.st = DCCC_S_RUN;
				else if (r_q.tick)
				begin
					if (r_q.tcnt >= acc_dly)
						r_d.st = DCCC_S_SLOW;
					else
						r_d.tcnt = r_q.tcnt + 8'h01;
				end
			end
			DCCC_S_SLOW:
			begin
				if (!slow_ok)
					r_d.st = DCCC_S_RUN;
			end
			default:
				r_d.st = DCCC_S_RUN;
		endcase

		// restart wins over the sequencer; clocks already running stay on
		if (restart)
		begin
			r_d.st   = DCCC_S_ACCEL;
			r_d.tcnt = '0;
		end
	end

	// single state register
	always_ff @(posedge sys_clk_in)
	begin
		if (!reset_n_in)
			r_q <= DCCC_REGS_RST;
		else
			r_q <= r_d;
	end

	// phase wrap decision on each update
	dccc_phase_wrap u_wrap (
		.sys_clk_in (sys_clk_in),
		.reset_n_in (reset_n_in),
		.upd_in     (r_q.tick),
		.sel_in     (r_q.cfg[DCCC_WRAP_LSB +: 2]),
		.delta_in   (ro_delta_in),
		.wrap_out   (pw_wrap),
		.delta_out  (pw_delta)
	);

	// outputs, all decoded from registered state
	assign wb_dat_o        = r_q.rdat;
	assign wb_ack_o        = r_q.ack;
	// gain shift applied in slow mode
	assign gain_shift_out  = r_q.cfg[DCCC_GAIN_LSB +: 5];
	assign slow_mode_out   = (r_q.st == DCCC_S_SLOW);
	assign update_tick_out = r_q.tick;
	assign fast_lock_out   = fl_on;
	// fast coefficient from select, else the lowpass field
	assign lpf_coef_out    = fl_on ? (DCCC_FL_COEF_BASE + 5'(r_q.cfg[DCCC_FL_SEL_LSB +: 2]))
		: r_q.cfg[DCCC_LPF_LSB +: 5];
	assign deci_coef_out   = r_q.cfg[DCCC_DECI_LSB +: 5];
	// robust decode flag straight from its bit
	assign robust_out      = r_q.cfg[DCCC_ROBUST_BIT];
	assign wrap_sel_out    = r_q.cfg[DCCC_WRAP_LSB +: 2];
	assign wrap_out        = pw_wrap;
	assign delta_out       = pw_delta;
	// integer mode zeroes the DAC once acceleration has ended
	assign dac_zero_out    = r_q.cfg[DCCC_INT_BIT] && (r_q.st != DCCC_S_ACCEL);
	assign holdover_out    = r_q.cfg[DCCC_HOLD_BIT];
	assign clocks_en_out   = r_q.clken;

	// checks
	sequence s_bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	sequence s_accel_end;
		(r_q.st == DCCC_S_ACCEL) ##1 (r_q.st == DCCC_S_RUN);
	endsequence

	bus_ack_once_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse");

	rsvd_zero_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		!r_q.cfg[DCCC_RSVD_BIT])
		else $error("reserved bit set");

	spare_store_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(wr_take && hit_cfg && wb_sel_i[3]) |=> r_q.cfg[DCCC_SPARE_BIT] == $past(wb_dat_i[25]))
		else $error("spare bit not stored");

	gain_write_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(wr_take && hit_cfg && wb_sel_i[3]) |=> gain_shift_out == $past(wb_dat_i[31:27]))
		else $error("gain shift not stored");

	fast_coef_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		fast_lock_out |-> lpf_coef_out == 5'(11 + r_q.cfg[23:22]))
		else $error("fast lock coefficient wrong");

	norm_coef_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(!r_q.cfg[21] && r_q.st != DCCC_S_ACCEL) |-> lpf_coef_out == r_q.cfg[12:8])
		else $error("normal coefficient wrong");

	accel_fast_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(r_q.st == DCCC_S_ACCEL) |-> fast_lock_out && sts[DCCC_STS_FAST])
		else $error("fast lock off during acceleration");

	startup_clk_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		$rose(clocks_en_out) |-> $past(r_q.st) == DCCC_S_ACCEL && $past(r_q.tick))
		else $error("clocks enabled before acceleration done");

	accel_exit_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		s_accel_end |-> clocks_en_out)
		else $error("acceleration ended without clocks");

	slow_guard_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		$rose(slow_mode_out) |-> $past(r_q.st) == DCCC_S_WAIT && $past(slow_ok))
		else $error("slow mode entered without delay");

	dac_zero_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(r_q.cfg[4] && r_q.st == DCCC_S_RUN) |-> dac_zero_out)
		else $error("integer mode did not zero DAC");

	hold_slow_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		holdover_out |=> !slow_mode_out || !holdover_out)
		else $error("slow mode during holdover");

endmodule : dccc_config

// >>> tb_top.sv
// Purpose: self-checking bench for the calibration config block
// Assumes: 1-cycle registered ack; accel set short (rate 0, dur 0, delay 0)
// Notes:   reads are scoreboarded through a queue; port levels checked inline
`timescale 1ns/1ps
module tb_top;
	import dccc_pkg::*;
	localparam int TMO_CYC = 30000;  // far above the expected run length
	logic              sys_clk_in;      // bench clock
	logic              reset_n_in;      // sync reset, active low
	logic              wb_cyc_i;        // bus cycle
	logic              wb_stb_i;        // strobe
	logic              wb_we_i;         // write enable
	logic [7:0]        wb_adr_i;        // byte address
	logic [3:0]        wb_sel_i;        // byte lanes
	logic [31:0]       wb_dat_i;        // write data
	logic [31:0]       wb_dat_o;        // read data
	logic              wb_ack_o;        // acknowledge
	logic signed [7:0] ro_delta_in;     // ring delta stimulus
	logic [4:0]        gain_shift_out;  // gain shift
	logic              slow_mode_out;   // slow mode
	logic              update_tick_out; // update tick
	logic              fast_lock_out;   // fast lock
	logic [4:0]        lpf_coef_out;    // lowpass coefficient
	logic [4:0]        deci_coef_out;   // decimator coefficient
	logic              robust_out;      // robust decode
	logic [1:0]        wrap_sel_out;    // wrap select
	logic              wrap_out;        // wrap seen
	logic signed [7:0] delta_out;       // corrected delta
	logic              dac_zero_out;    // dac forced zero
	logic              holdover_out;    // holdover
	logic              clocks_en_out;   // clocks enabled
	logic [31:0]       exp_q[$];        // expected read data, oldest first
	logic [31:0]       shadow;          // bench copy of the config word
	int                fails;           // mismatches
	int                n_tests;         // comparisons
	int                cyc_cnt;         // timeout counter
	integer            seed;            // random seed

	dccc_config i_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ro_delta_in(ro_delta_in),
		.gain_shift_out(gain_shift_out), .slow_mode_out(slow_mode_out),
		.update_tick_out(update_tick_out), .fast_lock_out(fast_lock_out),
		.lpf_coef_out(lpf_coef_out), .deci_coef_out(deci_coef_out),
		.robust_out(robust_out), .wrap_sel_out(wrap_sel_out), .wrap_out(wrap_out),
		.delta_out(delta_out), .dac_zero_out(dac_zero_out),
		.holdover_out(holdover_out), .clocks_en_out(clocks_en_out));

	// free-running 100 MHz clock
	always #5 sys_clk_in = ~sys_clk_in;

	// closing report, the single exit point
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	// four-state compare so an unknown matches only the same unknown
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// one classic cycle; request held until ack is sampled, then released
	task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
		input logic [31:0] dat);
		@(posedge sys_clk_in);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		do @(posedge sys_clk_in); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge sys_clk_in);
	endtask : bus

	// note the expected word, the monitor compares it when ack shows
	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		exp_q.push_back(exp);
		bus(1'b0, adr, 4'hf, 32'h0);
	endtask : rd

	// config write with lane merge into the shadow, then port levels
	task automatic wr_cfg(input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] lm;
		lm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		shadow = ((shadow & ~lm) | (wd & lm)) & DCCC_CFG_RW_MASK;
		bus(1'b1, DCCC_CFG_OFS, sel, wd);
		check(32'(gain_shift_out), 32'(shadow[31:27]), "gain");
		check(32'(deci_coef_out), 32'(shadow[20:16]), "deci");
		check(32'(robust_out), 32'(shadow[15]), "robust");
		check(32'(wrap_sel_out), 32'(shadow[14:13]), "wrapsel");
		check(32'(holdover_out), 32'(shadow[5]), "hold");
		check(32'(fast_lock_out), 32'(shadow[21]), "fast");
		check(32'(lpf_coef_out), shadow[21] ? 32'(5'h0b + shadow[23:22])
			: 32'(shadow[12:8]), "lpf");
	endtask : wr_cfg

	// wait for one tick, bounded; gap returns cycles since the call
	task automatic tick(output int gap);
		for (gap = 1; gap < 2000; gap++)
		begin
			@(posedge sys_clk_in);
			if (update_tick_out === 1'b1)
				break;
		end
	endtask : tick

	// read monitor: pops the oldest note whenever read data is acked
	always @(posedge sys_clk_in)
		if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i)
		begin
			if (exp_q.size() == 0)
				check(wb_dat_o, 32'hx, "unexpected read");
			else
				check(wb_dat_o, exp_q.pop_front(), "read");
		end

	// hang guard, counted as a mismatch
	always @(posedge sys_clk_in)
	begin
		cyc_cnt++;
		if (cyc_cnt == TMO_CYC)
		begin
			fails++;
			final_report();
		end
	end

	// wrap table: select code, delta, expected wrap, expected delta
	logic [1:0]        w_code [8] = '{0, 0, 0, 1, 1, 1, 2, 2};
	logic signed [7:0] w_d    [8] = '{20, 17, -20, 18, 17, -18, 13, 12};
	logic              w_wrap [8] = '{1, 0, 1, 1, 0, 1, 1, 0};
	logic signed [7:0] w_res  [8] = '{-14, 17, 14, -16, 17, 16, -21, 12};

	// main sequence
	initial
	begin : main_seq
		int          g;
		logic [31:0] wd;
		logic [3:0]  s;
		sys_clk_in = 1'b0;
		reset_n_in = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		ro_delta_in = 8'sh00;
		seed = 32'he9ef;
		shadow = DCCC_CFG_RESET;
		repeat (3) @(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		@(posedge sys_clk_in);
		check(32'({fast_lock_out, clocks_en_out}), 32'h2, "startup lock");
		rd(DCCC_CFG_OFS, 32'h800a_9800);
		// short accel so the startup sequence ends quickly
		bus(1'b1, DCCC_ACC_OFS, 4'hf, 32'h0);
		for (g = 0; g < 5000 && clocks_en_out !== 1'b1; g++) @(posedge sys_clk_in);
		check(32'({clocks_en_out, fast_lock_out}), 32'h2, "accel end");
		check(32'(lpf_coef_out), 32'h18, "lpf normal");
		// unmapped place reads zero and swallows writes
		bus(1'b1, 8'h0c, 4'hf, 32'hffff_ffff);
		rd(8'h0c, 32'h0);
		// reserved bit 26 stays zero, spare bit 25 keeps its value
		wr_cfg(shadow | 32'h0600_0000, 4'hf);
		rd(DCCC_CFG_OFS, shadow);
		// random words within legal field ranges, random lanes
		repeat (6)
		begin
			wd = $random(seed);
			wd[20:16] = 5'($unsigned($random(seed)) % 11);
			wd[12:8] = 5'($unsigned($random(seed)) % 25);
			s = 4'($random(seed));
			// slow enable kept off whenever the merged word has integer or holdover
			if ((s[0] ? wd[5:4] : shadow[5:4]) != 2'b00)
			begin
				wd[24] = 1'b0;
				s[3] = 1'b1;
			end
			wr_cfg(wd, s);
			rd(DCCC_CFG_OFS, shadow);
		end
		wr_cfg(32'h800a_9800, 4'hf);
		// every fast-lock coefficient code
		for (int k = 0; k < 4; k++)
			wr_cfg((shadow & ~32'h00e0_0000) | (32'(k) << 22) | 32'h0020_0000, 4'hf);
		wr_cfg(shadow & ~32'h0020_0000, 4'h4);
		// wrap decisions for codes 0, 1 and 2, both sides of each threshold
		for (int k = 0; k < 8; k++)
		begin
			wr_cfg((shadow & ~32'h6000) | (32'(w_code[k]) << 13), 4'h2);
			ro_delta_in <= w_d[k];
			tick(g);
			tick(g);
			repeat (2) @(posedge sys_clk_in);
			check(32'(wrap_out), 32'(w_wrap[k]), "wrap");
			check(32'(delta_out), 32'(w_res[k]), "delta");
		end
		wr_cfg(shadow & ~32'h6000, 4'h2);
		// slow mode after the start delay, then update spacing per rate
		wr_cfg(shadow | 32'h0100_0000, 4'h8);
		for (g = 0; g < 400 && slow_mode_out !== 1'b1; g++) @(posedge sys_clk_in);
		check(32'(slow_mode_out), 32'h1, "slow entry");
		tick(g);
		tick(g);
		check(32'(g), DCCC_BASE_CYC, "tick rate 0");
		bus(1'b1, DCCC_ACC_OFS, 4'hf, 32'h0002_0000);
		tick(g);
		tick(g);
		check(32'(g), 3 * DCCC_BASE_CYC, "tick rate 2");
		bus(1'b1, DCCC_ACC_OFS, 4'hf, 32'h0);
		// integer mode with slow enable cleared first
		wr_cfg(shadow & ~32'h0100_0000, 4'h8);
		// the sequencer leaves slow mode one cycle after the enable drops
		@(posedge sys_clk_in);
		check(32'(slow_mode_out), 32'h0, "slow exit");
		wr_cfg(shadow | 32'h30, 4'h1);
		check(32'(dac_zero_out), 32'h1, "dac zero");
		// restart acceleration: fast lock forced, dac not zeroed meanwhile
		bus(1'b1, DCCC_ACC_OFS, 4'hf, 32'h8000_0000);
		check(32'({fast_lock_out, dac_zero_out}), 32'h2, "restart");
		rd(DCCC_ACC_OFS, 32'h0);
		tick(g);
		tick(g);
		repeat (2) @(posedge sys_clk_in);
		check(32'({fast_lock_out, dac_zero_out}), 32'h1, "after restart");
		rd(DCCC_CFG_OFS, shadow);
		// status: clocks on, holdover, dac zero; no wrap at code 0 for delta 12
		rd(DCCC_STS_OFS, 32'h0000_0070);
		repeat (3) @(posedge sys_clk_in);
		check(32'(exp_q.size()), 32'h0, "reads pending");
		final_report();
	end : main_seq
endmodule : tb_top
